/* File: core/dbs_port.sv */
// Device side of a double-data-rate, burst-of-four, common-I/O memory port.
// Assumes link_clk is the controller's true input strobe; its falling edge
// stands for the rising edge of the complementary strobe.
`timescale 1ns/1ps
module dbs_port #(
  parameter int DATA_W = 36, // 18 or 36
  parameter int RECAL_CYC = dbs_pkg::RECAL_CYC, // Tracking step interval
  localparam int NB = DATA_W / dbs_pkg::BYTE_W, // Enables per word
  localparam int AW = (DATA_W == 36) ? dbs_pkg::ADDR_W_X36 : dbs_pkg::ADDR_W_X18 // Address width
) (
  input logic clk, // Core clock, calibration
  input logic rst, // Synchronous reset, active high
  input logic link_clk, // True input strobe from controller
  input logic load_n, // Load new address, active low
  input logic read_sel, // High read, low write
  input logic [AW-1:0] address_in, // Word address
  input logic [NB-1:0] byte_write_n, // Byte write enables, active low
  input logic [DATA_W-1:0] dq_in, // Shared data bus, input side
  output logic [DATA_W-1:0] dq_out, // Shared data bus, output side
  output logic dq_oe_n, // Low while the device drives the bus
  output logic echo_strobe_true, // Echo of the output timing
  output logic echo_strobe_comp, // Inverted echo
  output logic read_valid_flag, // Read data valid indicator
  input logic dll_bypass_n, // Low bypasses the delay loop
  input logic impedance_pin, // Sense: driver stronger than target
  output logic [5:0] drive_code, // Driver impedance code, link side
  output logic cal_done // Start-up calibration finished
);

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int BL = dbs_pkg::BURST_LEN;
  localparam int NS = 3; // Coherent sources: pending, newest, older

  typedef logic [BL-1:0][DATA_W-1:0] dbs_burst_t; // Four data words
  typedef logic [BL-1:0][NB-1:0] dbs_mask_t; // Four enable groups

  // ----------------------------------------
  // Link domain reset and mode
  // ----------------------------------------
  logic rst_l; // Reset retimed onto link_clk
  logic loop_on; // Loop enable, synchronised
  dbs_pkg::dbs_lat_e lat_mode; // Current read latency

  dbs_sync #(.W(1)) u_rst (.clk(link_clk), .rst(1'b0), .d(rst), .q(rst_l));
  dbs_sync #(.W(1)) u_dll (.clk(link_clk), .rst(rst_l), .d(dll_bypass_n), .q(loop_on));

  // Bypassed loop falls back to the short latency
  assign lat_mode = loop_on ? dbs_pkg::DBS_LAT_2P5 : dbs_pkg::DBS_LAT_1;

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  logic mid_burst_reg; // Second cycle of a two-cycle burst
  logic cmd_take; // Command accepted this edge
  logic rd_cmd; // Read accepted
  logic wr_cmd; // Write accepted

  // Commands only on every other edge; load high is a no-op
  assign cmd_take = !load_n && !mid_burst_reg;
  assign rd_cmd = cmd_take && read_sel;
  assign wr_cmd = cmd_take && !read_sel;

  // Burst occupies two edges regardless of direction
  always_ff @(posedge link_clk) begin
    if (rst_l) begin
      mid_burst_reg <= 1'b0;
    end else begin
      mid_burst_reg <= cmd_take;
    end
  end

  // ----------------------------------------
  // Command pipelines
  // ----------------------------------------
  logic [4:1] rd_v_reg; // Read issued n cycles ago
  logic [AW-1:0] rd_a_reg [4:1]; // Its start address
  logic [3:1] wr_v_reg; // Write issued n cycles ago
  logic [AW-1:0] wr_a_reg [3:1]; // Its start address

  // Address captured on the command edge itself
  always_ff @(posedge link_clk) begin
    if (rst_l) begin
      rd_v_reg <= '0;
      wr_v_reg <= '0;
    end else begin
      rd_v_reg <= {rd_v_reg[3:1], rd_cmd};
      wr_v_reg <= {wr_v_reg[2:1], wr_cmd};
    end
  end

  // Address shift, no reset needed beside the valid bits
  always_ff @(posedge link_clk) begin
    rd_a_reg[1] <= address_in;
    wr_a_reg[1] <= address_in;
    for (int i = 2; i <= 4; i++) begin
      rd_a_reg[i] <= rd_a_reg[i-1];
    end
    for (int i = 2; i <= 3; i++) begin
      wr_a_reg[i] <= wr_a_reg[i-1];
    end
  end

  // ----------------------------------------
  // Write data capture
  // ----------------------------------------
  logic [DATA_W-1:0] dq_neg_reg; // Word taken on the falling edge
  logic [NB-1:0] bw_neg_reg; // Its enables, same edge
  dbs_burst_t asm_dat_reg; // Burst being assembled
  dbs_mask_t asm_en_reg; // Its byte enables

  // Second and fourth words arrive on the complementary edge
  always_ff @(negedge link_clk) begin
    dq_neg_reg <= dq_in;
    bw_neg_reg <= byte_write_n;
  end

  // Words land one cycle after the command, alternating edges
  always_ff @(posedge link_clk) begin
    if (rst_l) begin
      asm_en_reg <= '0;
    end else begin
      if (wr_v_reg[1]) begin
        asm_dat_reg[0] <= dq_in;
        asm_en_reg[0] <= ~byte_write_n;
      end
      if (wr_v_reg[2]) begin
        asm_dat_reg[1] <= dq_neg_reg;
        asm_en_reg[1] <= ~bw_neg_reg;
        asm_dat_reg[2] <= dq_in;
        asm_en_reg[2] <= ~byte_write_n;
      end
    end
  end

  // ----------------------------------------
  // Late-write buffers
  // ----------------------------------------
  dbs_burst_t buf_dat_reg [2]; // Index 0 newest, 1 older
  dbs_mask_t buf_en_reg [2]; // Enables kept per buffered burst
  logic [AW-1:0] buf_a_reg [2]; // Start address per buffer
  logic [1:0] buf_v_reg; // Buffer holds a burst
  dbs_burst_t pend_dat; // Complete burst on the push edge
  dbs_mask_t pend_en; // Its enables
  logic push; // Burst complete this edge
  logic commit; // Older buffer goes to the array

  assign push = wr_v_reg[3];
  assign commit = push && buf_v_reg[1];
  assign pend_dat = {dq_neg_reg, asm_dat_reg[2], asm_dat_reg[1], asm_dat_reg[0]};
  assign pend_en = {~bw_neg_reg, asm_en_reg[2], asm_en_reg[1], asm_en_reg[0]};

  // Each completed write pushes the older one into the array once both buffers hold a burst
  always_ff @(posedge link_clk) begin
    if (rst_l) begin
      buf_v_reg <= 2'h0;
    end else if (push) begin
      buf_v_reg <= {buf_v_reg[0], 1'b1};
      buf_dat_reg[1] <= buf_dat_reg[0];
      buf_en_reg[1] <= buf_en_reg[0];
      buf_a_reg[1] <= buf_a_reg[0];
      buf_dat_reg[0] <= pend_dat;
      buf_en_reg[0] <= pend_en;
      buf_a_reg[0] <= wr_a_reg[3];
    end
  end

  // ----------------------------------------
  // Storage array
  // ----------------------------------------
  logic [DATA_W-1:0] mem [2**AW]; // Main storage, one word per address

  // Four burst words, each byte only where enabled
  always_ff @(posedge link_clk) begin
    if (commit) begin
      for (int k = 0; k < BL; k++) begin
        for (int j = 0; j < NB; j++) begin
          if (buf_en_reg[1][k][j]) begin
            mem[buf_a_reg[1] + AW'(k)][j*dbs_pkg::BYTE_W +: dbs_pkg::BYTE_W] <=
              buf_dat_reg[1][k][j*dbs_pkg::BYTE_W +: dbs_pkg::BYTE_W];
          end
        end
      end
    end
  end

  // ----------------------------------------
  // Coherent lookup
  // ----------------------------------------
  dbs_burst_t src_dat [NS]; // Oldest first, newest last
  dbs_mask_t src_en [NS];
  logic [AW-1:0] src_a [NS];
  logic [NS-1:0] src_v;

  assign src_dat[0] = buf_dat_reg[1];
  assign src_dat[1] = buf_dat_reg[0];
  assign src_dat[2] = pend_dat;
  assign src_en[0] = buf_en_reg[1];
  assign src_en[1] = buf_en_reg[0];
  assign src_en[2] = pend_en;
  assign src_a[0] = buf_a_reg[1];
  assign src_a[1] = buf_a_reg[0];
  assign src_a[2] = wr_a_reg[3];
  assign src_v = {push, buf_v_reg[0], buf_v_reg[1]};

  // Array word overlaid by buffered bytes, newest write last
  function automatic logic [DATA_W-1:0] fetch(input logic [AW-1:0] a);
    logic [DATA_W-1:0] w;
    logic [AW-1:0] off;
    w = mem[a];
    off = '0;
    for (int s = 0; s < NS; s++) begin
      off = a - src_a[s];
      if (src_v[s] && off < AW'(BL)) begin
        for (int j = 0; j < NB; j++) begin
          if (src_en[s][off[1:0]][j]) begin
            w[j*dbs_pkg::BYTE_W +: dbs_pkg::BYTE_W] =
              src_dat[s][off[1:0]][j*dbs_pkg::BYTE_W +: dbs_pkg::BYTE_W];
          end
        end
      end
    end
    return w;
  endfunction

  // ----------------------------------------
  // Read slot selection
  // ----------------------------------------
  logic pos_hit; // Word due from the next rising edge
  logic neg_hit; // Word due from the next falling edge
  logic [AW-1:0] pos_addr; // Its address
  logic [AW-1:0] neg_addr;
  logic pos_vld; // Flag level for the rising half
  logic neg_vld; // Flag level for the falling half
  logic long_lat; // Loop locked

  assign long_lat = (lat_mode == dbs_pkg::DBS_LAT_2P5);

  // Long: word0 at +2.5, word1 +3, word2 +3.5, word3 +4
  // Short: word0 at +1, word1 +1.5, word2 +2, word3 +2.5
  assign pos_hit = long_lat ? (rd_v_reg[3] | rd_v_reg[4]) : (rd_v_reg[1] | rd_v_reg[2]);
  assign neg_hit = long_lat ? (rd_v_reg[2] | rd_v_reg[3]) : (rd_v_reg[1] | rd_v_reg[2]);
  assign pos_addr = long_lat
    ? (rd_v_reg[3] ? rd_a_reg[3] + AW'(1) : rd_a_reg[4] + AW'(3))
    : (rd_v_reg[1] ? rd_a_reg[1] : rd_a_reg[2] + AW'(2));
  assign neg_addr = long_lat
    ? (rd_v_reg[2] ? rd_a_reg[2] : rd_a_reg[3] + AW'(2))
    : (rd_v_reg[1] ? rd_a_reg[1] + AW'(1) : rd_a_reg[2] + AW'(3));
  // Flag rises a half before word0 and falls a half before word3
  assign pos_vld = long_lat ? (rd_v_reg[2] | rd_v_reg[3]) : rd_v_reg[1];
  assign neg_vld = long_lat ? rd_v_reg[2] : (rd_cmd | rd_v_reg[1]);

  // ----------------------------------------
  // Output launch
  // ----------------------------------------
  logic [DATA_W-1:0] pos_q_reg; // Word launched on the rising edge
  logic pos_oe_reg;
  logic pos_vld_reg;
  logic [DATA_W-1:0] neg_stage_reg; // Prepared a half cycle early
  logic neg_oe_stage_reg;
  logic neg_vld_stage_reg;
  logic [DATA_W-1:0] neg_q_reg; // Word launched on the falling edge
  logic neg_oe_reg;
  logic neg_vld_reg;

  // Both halves are looked up on the rising edge; the falling edge retimes
  always_ff @(posedge link_clk) begin
    if (rst_l) begin
      pos_q_reg <= '0;
      pos_oe_reg <= 1'b0;
      pos_vld_reg <= 1'b0;
      neg_stage_reg <= '0;
      neg_oe_stage_reg <= 1'b0;
      neg_vld_stage_reg <= 1'b0;
    end else begin
      pos_q_reg <= pos_hit ? fetch(pos_addr) : pos_q_reg;
      pos_oe_reg <= pos_hit;
      pos_vld_reg <= pos_vld;
      neg_stage_reg <= neg_hit ? fetch(neg_addr) : neg_stage_reg;
      neg_oe_stage_reg <= neg_hit;
      neg_vld_stage_reg <= neg_vld;
    end
  end

  // Complementary-edge launch
  always_ff @(negedge link_clk) begin
    if (rst_l) begin
      neg_q_reg <= '0;
      neg_oe_reg <= 1'b0;
      neg_vld_reg <= 1'b0;
    end else begin
      neg_q_reg <= neg_stage_reg;
      neg_oe_reg <= neg_oe_stage_reg;
      neg_vld_reg <= neg_vld_stage_reg;
    end
  end

  // Half-cycle select by strobe level; drivers drop once no word is due
  assign dq_out = link_clk ? pos_q_reg : neg_q_reg;
  assign dq_oe_n = ~(link_clk ? pos_oe_reg : neg_oe_reg);
  assign read_valid_flag = link_clk ? pos_vld_reg : neg_vld_reg;
  // Echoes share the data launch edges and never stop
  assign echo_strobe_true = link_clk;
  assign echo_strobe_comp = ~link_clk;

  // ----------------------------------------
  // Impedance calibration, core domain
  // ----------------------------------------
  logic zq_strong; // Sense level, synchronised
  dbs_pkg::dbs_cal_e cal_state_reg; // Search or tracking
  logic [dbs_pkg::CAL_CNT_W-1:0] step_cnt_reg; // Cycles to next step
  logic [dbs_pkg::CAL_CNT_W-1:0] init_cnt_reg; // Cycles since start
  logic [5:0] code_reg; // Current target code
  logic [5:0] sent_reg; // Last code handed to the link side
  logic step_due; // Step interval elapsed
  logic [5:0] code_step; // Code one step toward target
  logic xfer_busy;
  logic [dbs_pkg::CAL_CNT_W-1:0] step_len; // Interval for this state

  dbs_sync #(.W(1)) u_zq (.clk(clk), .rst(rst), .d(impedance_pin), .q(zq_strong));

  assign step_len = (cal_state_reg == dbs_pkg::DBS_CAL_INIT)
    ? dbs_pkg::CAL_CNT_W'(dbs_pkg::CAL_STEP_CYC - 1)
    : dbs_pkg::CAL_CNT_W'(RECAL_CYC - 1);
  assign step_due = (step_cnt_reg == step_len);
  // Saturating step; weaker when the driver is too strong
  assign code_step = zq_strong ? ((code_reg == 6'h00) ? code_reg : code_reg - 6'h01)
    : ((code_reg == dbs_pkg::CODE_MAX) ? code_reg : code_reg + 6'h01);

  // Fast search from mid code, then slow periodic tracking
  always_ff @(posedge clk) begin
    if (rst) begin
      cal_state_reg <= dbs_pkg::DBS_CAL_INIT;
      step_cnt_reg <= '0;
      init_cnt_reg <= '0;
      code_reg <= dbs_pkg::CODE_MID;
      cal_done <= 1'b0;
    end else begin
      step_cnt_reg <= step_due ? '0 : step_cnt_reg + 1'b1;
      if (step_due) begin
        code_reg <= code_step;
      end
      case (cal_state_reg)
        dbs_pkg::DBS_CAL_INIT: begin
          init_cnt_reg <= init_cnt_reg + 1'b1;
          // 64 steps of 16 cycles fit the 1024-cycle window
          if (init_cnt_reg == dbs_pkg::CAL_CNT_W'(dbs_pkg::CAL_LIMIT_CLK - 1)) begin
            cal_state_reg <= dbs_pkg::DBS_CAL_TRACK;
            cal_done <= 1'b1;
            step_cnt_reg <= '0;
          end
        end
        dbs_pkg::DBS_CAL_TRACK: begin
          cal_done <= 1'b1;
        end
        default: begin
          cal_state_reg <= dbs_pkg::DBS_CAL_INIT;
        end
      endcase
    end
  end

  // Hand a changed code across whenever the crossing is free
  always_ff @(posedge clk) begin
    if (rst) begin
      sent_reg <= dbs_pkg::CODE_MID;
    end else if (!xfer_busy && code_reg != sent_reg) begin
      sent_reg <= code_reg;
    end
  end

  // ----------------------------------------
  // Code crossing and safe update
  // ----------------------------------------
  logic [5:0] new_code; // Code arrived on the link side
  logic new_code_stb;
  logic code_pend_reg; // Arrived, not yet applied
  logic bus_quiet; // No read word due or on the bus

  dbs_word_xfer #(.W(6)) u_code (
    .src_clk(clk),
    .src_rst(rst),
    .src_load(!xfer_busy && code_reg != sent_reg),
    .src_data(code_reg),
    .src_busy(xfer_busy),
    .dst_clk(link_clk),
    .dst_rst(rst_l),
    .dst_data(new_code),
    .dst_strobe(new_code_stb)
  );

  assign bus_quiet = !(|rd_v_reg) && !rd_cmd && !pos_oe_reg && !neg_oe_stage_reg;

  // Drivers change strength only between read bursts, so data never glitches
  always_ff @(posedge link_clk) begin
    if (rst_l) begin
      drive_code <= dbs_pkg::CODE_MID;
      code_pend_reg <= 1'b0;
    end else begin
      if (bus_quiet && code_pend_reg) begin
        drive_code <= new_code;
      end
      // Fresh arrival wins over the apply clear
      code_pend_reg <= new_code_stb || (code_pend_reg && !bus_quiet);
    end
  end

endmodule

/* File: common/dbs_pkg.sv */
// Shared constants of the burst-of-four common-I/O static memory port.
// Assumes nothing; used only by dbs_port through dbs_pkg:: names.
package dbs_pkg;

  // ----------------------------------------
  // Data organisation
  // ----------------------------------------
  localparam int BYTE_W = 9; // Bits covered by one byte-write enable
  localparam int BURST_LEN = 4; // Words per access, reads and writes
  localparam int ADDR_W_X36 = 21; // Word address width, 36-bit part
  localparam int ADDR_W_X18 = 22; // Word address width, 18-bit part

  // ----------------------------------------
  // Output impedance calibration
  // ----------------------------------------
  localparam int CODE_W = 6; // Driver impedance code width
  localparam logic [5:0] CODE_MID = 6'h20; // Power-up code, mid range
  localparam logic [5:0] CODE_MAX = 6'h3F; // Strongest driver code
  localparam int CAL_LIMIT_CLK = 1024; // Final code reached within, in clocks
  localparam int CAL_STEPS = 64; // Code steps allowed in that window
  localparam int CAL_STEP_CYC = CAL_LIMIT_CLK / CAL_STEPS; // Cycles per step
  localparam int CAL_CNT_W = 14; // Width of calibration counters
  localparam int RECAL_CYC = 8192; // Periodic tracking step interval

  // ----------------------------------------
  // Modes and states
  // ----------------------------------------
  typedef enum logic [0:0] {
    DBS_LAT_2P5 = 1'b0, // Loop locked: 2.5 cycle read latency
    DBS_LAT_1 = 1'b1 // Loop bypassed: 1 cycle read latency
  } dbs_lat_e;

  typedef enum logic [0:0] {
    DBS_CAL_INIT = 1'b0, // Fast search after start-up
    DBS_CAL_TRACK = 1'b1 // Slow periodic drift tracking
  } dbs_cal_e;

endpackage

/* File: core/dbs_sync.sv */
// Two-flop level synchroniser, any width.
// Assumes each bit is an independent level; words must not pass here.
`timescale 1ns/1ps
module dbs_sync #(
  parameter int W = 1
) (
  input logic clk, // Destination clock
  input logic rst, // Synchronous reset, active high
  input logic [W-1:0] d, // Level from another domain
  output logic [W-1:0] q // Level safe to use in this domain
);

  // ----------------------------------------
  // Stages
  // ----------------------------------------
  logic [W-1:0] meta_reg; // First stage, read only by q

  // Plain two-stage chain
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule

/* File: core/dbs_word_xfer.sv */
// Toggle handshake that carries one word between two clock domains.
// Assumes the source waits while busy; the word stays stable until ack.
`timescale 1ns/1ps
module dbs_word_xfer #(
  parameter int W = 6
) (
  input logic src_clk, // Source clock
  input logic src_rst, // Source reset, active high
  input logic src_load, // Pulse: send src_data
  input logic [W-1:0] src_data, // Word to send
  output logic src_busy, // Level: transfer in flight
  input logic dst_clk, // Destination clock
  input logic dst_rst, // Destination reset, active high
  output logic [W-1:0] dst_data, // Received word, registered
  output logic dst_strobe // Pulse: dst_data just updated
);

  // ----------------------------------------
  // Source side
  // ----------------------------------------
  logic [W-1:0] hold_reg; // Word held stable for the far side
  logic req_reg; // Request toggle
  logic ack_sync; // Acknowledge toggle, synchronised
  logic seen_reg; // Destination copy of the toggle
  logic req_sync; // Request toggle, synchronised

  assign src_busy = req_reg ^ ack_sync;

  // Launch a word only while idle so hold_reg never moves under the reader
  always_ff @(posedge src_clk) begin
    if (src_rst) begin
      hold_reg <= '0;
      req_reg <= 1'b0;
    end else if (src_load && !src_busy) begin
      hold_reg <= src_data;
      req_reg <= ~req_reg;
    end
  end

  dbs_sync #(.W(1)) u_ack (.clk(src_clk), .rst(src_rst), .d(seen_reg), .q(ack_sync));
  dbs_sync #(.W(1)) u_req (.clk(dst_clk), .rst(dst_rst), .d(req_reg), .q(req_sync));

  // ----------------------------------------
  // Destination side
  // ----------------------------------------
  // Take the word once per toggle; seen_reg doubles as the acknowledge
  always_ff @(posedge dst_clk) begin
    if (dst_rst) begin
      seen_reg <= 1'b0;
      dst_data <= '0;
      dst_strobe <= 1'b0;
    end else begin
      dst_strobe <= req_sync ^ seen_reg;
      if (req_sync != seen_reg) begin
        seen_reg <= req_sync;
        dst_data <= hold_reg;
      end
    end
  end

endmodule

/* File: test/dbs_port_assertions.sv */
// Pin-level assertions for the memory port.
// Assumes a bind to dbs_port built 36 bits wide.
`timescale 1ns/1ps
module dbs_port_chk (
  input logic clk, // Core clock
  input logic rst, // Reset
  input logic link_clk, // Link clock
  input logic load_n, // Load, low
  input logic read_sel, // Read select
  input logic dll_bypass_n, // Loop in use
  input logic dq_oe_n, // Bus drive, low
  input logic read_valid_flag, // Valid
  input logic echo_strobe_true, // Echo
  input logic echo_strobe_comp, // Echo inverted
  input logic cal_done, // Start-up done
  input logic [5:0] drive_code // Driver code, link side
);
  // ----------------------------------------
  // Commands, true only at a link rise
  // ----------------------------------------
  wire cm = !link_clk && !load_n; // Clock sampled low means rise
  wire rc = cm && read_sel && dll_bypass_n; // Read, loop on
  wire bc = cm && read_sel && !dll_bypass_n; // Read, bypassed
  wire wc = cm && !read_sel; // Write
  int cyc; // Core clocks since reset, saturating
  // Saturate so the count never wraps on long runs
  always_ff @(posedge clk) cyc <= rst ? 0 : (cyc < 2000 ? cyc + 1 : cyc);
  property p_echo; @(posedge clk) disable iff (rst)
    echo_strobe_true == link_clk && echo_strobe_comp == !link_clk; endproperty
  a_echo: assert property (p_echo) else $error("echo off clock");
  property p_rd; @(link_clk) disable iff (rst) rc |-> ##6 !dq_oe_n [*4]; endproperty
  a_rd: assert property (p_rd) else $error("read burst not driven");
  property p_fl; @(link_clk) disable iff (rst) rc |-> ##5 read_valid_flag [*3]; endproperty
  a_fl: assert property (p_fl) else $error("valid flag late");
  property p_rel; @(link_clk) disable iff (rst) rc ##4 !cm |-> ##6 dq_oe_n; endproperty
  a_rel: assert property (p_rel) else $error("bus kept after burst");
  property p_byp; @(link_clk) disable iff (rst) bc |-> ##3 !dq_oe_n [*4]; endproperty
  a_byp: assert property (p_byp) else $error("bypass latency wrong");
  property p_wr; @(link_clk) disable iff (rst) wc |-> ##3 dq_oe_n [*4]; endproperty
  a_wr: assert property (p_wr) else $error("bus driven in write");
  property p_ce; @(posedge clk) disable iff (rst) cyc < 1000 |-> !cal_done; endproperty
  a_ce: assert property (p_ce) else $error("calibration done early");
  property p_cl; @(posedge clk) disable iff (rst) cyc > 1100 |-> cal_done; endproperty
  a_cl: assert property (p_cl) else $error("calibration late");
  // Strength may only move while the bus is released
  property p_code; @(link_clk) disable iff (rst) !dq_oe_n |-> $stable(drive_code); endproperty
  a_code: assert property (p_code) else $error("code moved during burst");
  c_rd: cover property (@(link_clk) rc);
  c_byp: cover property (@(link_clk) bc);
  c_wr: cover property (@(link_clk) wc);
endmodule
bind dbs_port dbs_port_chk dbs_port_chk_inst (.clk, .rst, .link_clk, .load_n, .read_sel,
  .dll_bypass_n, .dq_oe_n, .read_valid_flag, .echo_strobe_true, .echo_strobe_comp, .cal_done,
  .drive_code);

/* File: test/dbs_ctrl_model.sv */
// Controller model: commands and double-rate write data.
// Assumes a free-running link clock and the 36-bit build.
`timescale 1ns/1ps
module dbs_ctrl_model (
  input logic link_clk, // Link clock
  input logic [35:0] dq_out, // Read data
  output logic load_n = 1'h1, // Load, low
  output logic read_sel = 1'h1, // Read select
  output logic [20:0] address_in = 21'h00000, // Address
  output logic [3:0] byte_write_n = 4'hF, // Byte enables
  output logic [35:0] dq_in = 36'h000000000 // Write data
);
  // ----------------------------------------
  // Bus tasks; command held one cycle
  // ----------------------------------------
  task automatic cmd(input logic rs, input logic [20:0] a);
    @(posedge link_clk);
    load_n <= 1'h0;
    read_sel <= rs;
    address_in <= a;
    @(posedge link_clk);
    load_n <= 1'h1;
  endtask
  // Each word set one half early, so it is stable at its sampling edge
  task automatic wr(input logic [20:0] a, input logic [143:0] d, input logic [15:0] bw);
    cmd(1'h0, a);
    for (int k = 0; k < 4; k++) begin
      @(link_clk);
      dq_in <= d[k*36+:36];
      byte_write_n <= bw[k*4+:4];
    end
    @(link_clk);
    dq_in <= ~dq_in; // Released bus must not echo the last word
    byte_write_n <= 4'hF;
  endtask
  task automatic rd(input logic [20:0] a, input int lat, output logic [143:0] q);
    cmd(1'h1, a);
    repeat (lat) @(link_clk);
    for (int k = 0; k < 4; k++) begin
      if (k > 0) @(link_clk);
      #16 q[k*36+:36] = dq_out;
    end
  endtask
endmodule

/* File: test/testbench.sv */
// Bench for the memory port through the controller model.
// Assumes the 36-bit build and a short tracking interval.
`timescale 1ns/1ps
module testbench;
  logic clk = 1'h0; // Core clock
  logic link_clk = 1'h0; // Link clock
  logic rst = 1'h1; // Reset
  logic dll_bypass_n = 1'h1; // Loop in use
  logic impedance_pin = 1'h1; // Driver reads too strong
  logic load_n; // From model
  logic read_sel; // From model
  logic [20:0] address_in; // From model
  logic [3:0] byte_write_n; // From model
  logic [35:0] dq_in; // From model
  logic [35:0] dq_out; // Read data
  logic dq_oe_n; // Bus drive
  logic [5:0] drive_code; // Impedance code
  logic cal_done; // Start-up done
  int error_cnt = 0; // Mismatches
  int num_checks = 0; // Comparisons
  logic [143:0] m_a; // Newest burst at the base
  logic [143:0] q; // Last burst read
  localparam logic [20:0] BASE = 21'h1FFFFE; // Bursts here wrap
  always #2.5 clk = ~clk;
  always #32 link_clk = ~link_clk;
  dbs_port #(.DATA_W(36), .RECAL_CYC(64)) dbs_port_inst (.clk, .rst, .link_clk, .load_n,
    .read_sel, .address_in, .byte_write_n, .dq_in, .dq_out, .dq_oe_n, .echo_strobe_true(),
    .echo_strobe_comp(), .read_valid_flag(), .dll_bypass_n, .impedance_pin, .drive_code,
    .cal_done);
  dbs_ctrl_model dbs_ctrl_model_inst (.link_clk, .dq_out, .load_n, .read_sel, .address_in,
    .byte_write_n, .dq_in);
  // ----------------------------------------
  // Compare and report
  // ----------------------------------------
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  function automatic logic [143:0] pat(input logic [7:0] s);
    for (int k = 0; k < 4; k++) pat[k*36+:36] = {s, 4'h9, s, 8'(k), s};
  endfunction
  task automatic rd_chk(input logic [20:0] a, input int lat, input logic [143:0] e);
    dbs_ctrl_model_inst.rd(a, lat, q);
    for (int k = 0; k < 4; k++) check(q[k*36+:36], e[k*36+:36]);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_start;
    check(drive_code, 6'h20);
    check(cal_done, 1'h0);
    check(dq_oe_n, 1'h1);
    $display("start done");
  endtask
  // Word k leaves byte k alone, so each enable acts per word
  task automatic t_merge;
    logic [143:0] d;
    logic [143:0] e;
    d = pat(8'h11);
    e = pat(8'h22);
    dbs_ctrl_model_inst.wr(BASE, d, 16'h0000);
    rd_chk(BASE, 5, d);
    for (int k = 0; k < 4; k++) m_a[k*36+:36] = e[k*36+:36] ^
      ((e[k*36+:36] ^ d[k*36+:36]) & (36'h1FF << (9 * k)));
    dbs_ctrl_model_inst.wr(BASE, e, 16'h8421);
    rd_chk(BASE, 5, m_a);
    $display("merge done");
  endtask
  // Two later writes push the base burst out to the array
  task automatic t_commit;
    logic [143:0] f;
    f = pat(8'h33);
    dbs_ctrl_model_inst.wr(BASE + 21'h00004, f, 16'h0000);
    dbs_ctrl_model_inst.wr(21'h00100, pat(8'h44), 16'h0000);
    rd_chk(BASE + 21'h00002, 5, {f[71:0], m_a[143:72]});
    $display("commit done");
  endtask
  task automatic t_bypass;
    @(posedge clk) dll_bypass_n <= 1'h0;
    repeat (4) @(posedge link_clk);
    rd_chk(BASE, 2, m_a);
    @(posedge clk) dll_bypass_n <= 1'h1;
    repeat (4) @(posedge link_clk);
    $display("bypass done");
  endtask
  task automatic t_cal;
    for (int i = 0; i < 2000 && cal_done !== 1'h1; i++) @(posedge clk);
    repeat (64) @(posedge clk);
    check(cal_done, 1'h1);
    check(drive_code < 6'h20, 1'h1);
    $display("calibration done");
  endtask
  // Link reset lags, so hold through link edges as well
  initial begin
    repeat (4) @(posedge link_clk);
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    #1 t_start;
    repeat (3) @(posedge link_clk);
    t_merge;
    t_commit;
    t_bypass;
    t_cal;
    print_verdict;
  end
  // Calibration alone takes about 5 us; allow generous margin
  initial begin
    #30000 error_cnt++;
    print_verdict;
  end
endmodule
